//--- logic/ptm_params.svh
// Register offsets, field positions, reset values and sizes for the timer.
// Included by the package and the timer module; definitions only.
`ifndef PTM_PARAMS_SVH
`define PTM_PARAMS_SVH

`define PTM_OFS_CTRL0     8'h00
`define PTM_OFS_MODE      8'h04
`define PTM_OFS_CNT_LO    8'h08
`define PTM_OFS_CNT_HI    8'h0c
`define PTM_OFS_CMPA_LO   8'h10
`define PTM_OFS_CMPA_HI   8'h14
`define PTM_OFS_PER_LO    8'h18
`define PTM_OFS_PER_HI    8'h1c

`define PTM_CTRL0_ON_BIT  3
`define PTM_MODE_SEL_HI   7
`define PTM_MODE_SEL_LO   6
`define PTM_PIN_SEL_HI    5
`define PTM_PIN_SEL_LO    4
`define PTM_LVL_BIT       3
`define PTM_INV_BIT       2
`define PTM_CAPSRC_BIT    1
`define PTM_CLRSRC_BIT    0

`define PTM_RESET_BYTE    8'h00
`define PTM_CNT_W         10

`endif

//--- logic/ptm_pkg.sv
// Types shared by the periodic timer files.
// Assumes ptm_params.svh is on the include path.
`include "ptm_params.svh"

package ptm_pkg;
    typedef enum logic [1:0] {
        PTM_MODE_CMP = 2'h0,
        PTM_MODE_CAP = 2'h1,
        PTM_MODE_PWM = 2'h2,
        PTM_MODE_TMR = 2'h3
    } ptm_mode_t;

    typedef enum logic [2:0] {
        PTM_BUS_IDLE = 3'h1,
        PTM_BUS_WR = 3'h2,
        PTM_BUS_RD = 3'h4
    } ptm_bus_state_t;
endpackage : ptm_pkg

//--- logic/ptm_timer.sv
// Periodic 10-bit timer with mode control, count and compare registers,
// reached over an AHB-Lite slave. Assumes one clock, synchronous pins.
// Summary of operation
// - Mode field: 00 compare output, 01 capture, 10 PWM/pulse, 11 timer.
// - Timer mode: pin level undefined, pin controls have no effect.
// - Compare mode A match: 00 hold, 01 low, 10 high, 11 toggle.
// - PWM mode pin select: inactive, active, PWM, single pulse.
// - Capture pin select: rising, falling, both edges, disabled.
// - Requested level equal to current level gives no visible change.
// - Rising counter_on returns pin to its initial level.
// - Compare mode: level bit sets initial low or high.
// - PWM and pulse modes: level bit sets active level.
// - Single pulse: pin takes level bit on counter_on rise.
// - Invert bit inverts output pin in compare and PWM modes; when clear, pin passes through.
// - Capture source bit picks capture pin or external clock pin.
// - Clear source 1: A match clears counter.
// - Clear source 0: P match clears; overflow only if period zero.
// - Clear source ignored in PWM, pulse and capture modes.
// - Count readable as low byte and two high bits; rest zero.
// - Compare A 10-bit read/write as low and high registers.
// - Period compare 10-bit read/write as low and high registers.
// - 10-bit up-counter compared against A and P values.
// - counter_on rise clears counter; fall stops and keeps count.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "ptm_params.svh"

module ptm_timer
    import ptm_pkg::*;
#(
    parameter int CNT_W = `PTM_CNT_W
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic capture_input_pin,
    input wire logic external_clock_pin,
    output logic timer_output_pin
);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [7:0] ctrl0_reg;
    logic [7:0] mode_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cmpa_reg;
    logic [CNT_W-1:0] per_reg;
    logic [7:0] waddr_reg;
    logic wpend_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_next;
    logic [CNT_W-1:0] cap_val_reg;
    logic cap_pend_reg;

    wire logic take = hsel && hready && htrans[1];
    wire logic wr_now = wpend_reg;
    wire logic wr_ctrl0 = wr_now && waddr_reg == `PTM_OFS_CTRL0;
    wire logic wr_mode = wr_now && waddr_reg == `PTM_OFS_MODE;
    wire logic wr_a_lo = wr_now && waddr_reg == `PTM_OFS_CMPA_LO;
    wire logic wr_a_hi = wr_now && waddr_reg == `PTM_OFS_CMPA_HI;
    wire logic wr_p_lo = wr_now && waddr_reg == `PTM_OFS_PER_LO;
    wire logic wr_p_hi = wr_now && waddr_reg == `PTM_OFS_PER_HI;

    // Read mux; unmapped addresses read zero, answer is still OKAY
    always_comb begin
        rd_next = 32'h0;
        unique case (haddr[7:0])
            `PTM_OFS_CTRL0: rd_next = {24'h0, ctrl0_reg};
            `PTM_OFS_MODE: rd_next = {24'h0, mode_reg};
            `PTM_OFS_CNT_LO: rd_next = {24'h0, cnt_reg[7:0]};
            `PTM_OFS_CNT_HI: rd_next = {30'h0, cnt_reg[9:8]};
            `PTM_OFS_CMPA_LO: rd_next = {24'h0, cmpa_reg[7:0]};
            `PTM_OFS_CMPA_HI: rd_next = {30'h0, cmpa_reg[9:8]};
            `PTM_OFS_PER_LO: rd_next = {24'h0, per_reg[7:0]};
            `PTM_OFS_PER_HI: rd_next = {30'h0, per_reg[9:8]};
            default: rd_next = 32'h0;
        endcase
    end

    // Zero wait states: read data is registered during the address phase
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wpend_reg <= 1'b0;
            waddr_reg <= 8'h00;
            hrdata_reg <= 32'h0;
        end else begin
            wpend_reg <= take && hwrite;
            if (take) begin
                waddr_reg <= haddr[7:0];
            end
            if (take && !hwrite) begin
                hrdata_reg <= rd_next;
            end
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // Control and compare registers
    // ------------------------------------------------------------
    wire ptm_mode_t mode =
        ptm_mode_t'(mode_reg[`PTM_MODE_SEL_HI:`PTM_MODE_SEL_LO]);
    wire logic [1:0] pin_sel = mode_reg[`PTM_PIN_SEL_HI:`PTM_PIN_SEL_LO];
    wire logic lvl = mode_reg[`PTM_LVL_BIT];
    wire logic inv = mode_reg[`PTM_INV_BIT];
    wire logic cap_src = mode_reg[`PTM_CAPSRC_BIT];
    wire logic clr_src = mode_reg[`PTM_CLRSRC_BIT];
    wire logic on_bit = ctrl0_reg[`PTM_CTRL0_ON_BIT];
    wire logic pulse_mode = mode == PTM_MODE_PWM && pin_sel == 2'h3;

    logic on_d_reg;
    wire logic on_rise = on_bit && !on_d_reg;

    wire logic [CNT_W-1:0] cnt_max = '1;
    wire logic a_match = on_bit && cnt_reg == cmpa_reg;
    wire logic p_match = on_bit && cnt_reg == per_reg;
    wire logic ovf = on_bit && cnt_reg == cnt_max;

    // Single pulse ends on an A match, which clears counter_on itself
    wire logic pulse_end = pulse_mode && a_match;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl0_reg <= `PTM_RESET_BYTE;
            mode_reg <= `PTM_RESET_BYTE;
            cmpa_reg <= '0;
            per_reg <= '0;
            on_d_reg <= 1'b0;
        end else begin
            on_d_reg <= on_bit;
            if (wr_ctrl0) begin
                ctrl0_reg <= {hwdata[7:3], 3'h0};
            end else if (pulse_end) begin
                ctrl0_reg[`PTM_CTRL0_ON_BIT] <= 1'b0;
            end
            if (wr_mode) begin
                mode_reg <= hwdata[7:0];
            end
            if (wr_a_lo) begin
                cmpa_reg[7:0] <= hwdata[7:0];
            end
            if (wr_a_hi) begin
                cmpa_reg[9:8] <= hwdata[1:0];
            end
            // Capture wins over a bus write to compare A in the same cycle
            if (cap_pend_reg) begin
                cmpa_reg <= cap_val_reg;
            end
            if (wr_p_lo) begin
                per_reg[7:0] <= hwdata[7:0];
            end
            if (wr_p_hi) begin
                per_reg[9:8] <= hwdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic clr_cnt;
    always_comb begin
        clr_cnt = 1'b0;
        unique case (mode)
            PTM_MODE_CMP, PTM_MODE_TMR: begin
                if (clr_src) begin
                    clr_cnt = a_match;
                end else begin
                    clr_cnt = (per_reg != '0) ? p_match : ovf;
                end
            end
            // Clear source has no say here: P match clears, or overflow when period is zero
            PTM_MODE_CAP: clr_cnt = (per_reg != '0) ? p_match : ovf;
            PTM_MODE_PWM: clr_cnt = pulse_mode ? 1'b0 :
                ((per_reg != '0) ? p_match : ovf);
        endcase
    end

    // Capture edge detect on the selected source
    wire logic cap_in = cap_src ? external_clock_pin : capture_input_pin;
    logic cap_d_reg;
    wire logic cap_rise = cap_in && !cap_d_reg;
    wire logic cap_fall = !cap_in && cap_d_reg;
    logic cap_hit;
    always_comb begin
        cap_hit = 1'b0;
        unique case (pin_sel)
            2'h0: cap_hit = cap_rise;
            2'h1: cap_hit = cap_fall;
            2'h2: cap_hit = cap_rise || cap_fall;
            2'h3: cap_hit = 1'b0;
        endcase
    end
    wire logic do_cap = on_bit && mode == PTM_MODE_CAP && cap_hit;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            cap_d_reg <= 1'b0;
        end else begin
            cap_d_reg <= cap_in;
            if (on_rise) begin
                cnt_reg <= '0;
            end else if (on_bit && !pulse_end) begin
                cnt_reg <= clr_cnt ? '0 : cnt_reg + 1'b1;
            end
        end
    end

    // Captured count lands in compare A; a bus write in the same cycle loses
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cap_val_reg <= '0;
        end else if (do_cap) begin
            cap_val_reg <= cnt_reg;
        end
    end

    // ------------------------------------------------------------
    // Output pin
    // ------------------------------------------------------------
    logic cmp_lvl_reg;
    logic cmp_lvl_next;
    always_comb begin
        cmp_lvl_next = cmp_lvl_reg;
        if (on_rise) begin
            cmp_lvl_next = lvl;
        end else if (a_match) begin
            unique case (pin_sel)
                2'h0: cmp_lvl_next = cmp_lvl_reg;
                2'h1: cmp_lvl_next = 1'b0;
                2'h2: cmp_lvl_next = 1'b1;
                2'h3: cmp_lvl_next = !cmp_lvl_reg;
            endcase
        end
    end

    logic pulse_lvl_reg;
    logic pulse_lvl_next;
    // Leading edge must show in the cycle after counter_on rises
    always_comb begin
        pulse_lvl_next = pulse_lvl_reg;
        if (on_rise) begin
            pulse_lvl_next = lvl;
        end else if (pulse_end || !on_bit) begin
            pulse_lvl_next = !lvl;
        end
    end
    wire logic pwm_active = cmpa_reg >= (per_reg == '0 ? 11'h400 :
        {1'b0, per_reg}) ? 1'b1 : cnt_reg < cmpa_reg;
    logic pwm_lvl;
    always_comb begin
        pwm_lvl = !lvl;
        unique case (pin_sel)
            2'h0: pwm_lvl = !lvl;
            2'h1: pwm_lvl = lvl;
            2'h2: pwm_lvl = pwm_active ? lvl : !lvl;
            2'h3: pwm_lvl = pulse_lvl_next;
        endcase
    end

    logic pin_raw;
    always_comb begin
        pin_raw = 1'b0;
        unique case (mode)
            PTM_MODE_CMP: pin_raw = cmp_lvl_next;
            PTM_MODE_PWM: pin_raw = pwm_lvl;
            PTM_MODE_CAP: pin_raw = 1'b0;
            // Pin is undefined here; held low and not inverted
            PTM_MODE_TMR: pin_raw = 1'b0;
        endcase
    end
    // Capture and timer modes have no output function: no inversion either
    wire logic pin_quiet = mode == PTM_MODE_TMR || mode == PTM_MODE_CAP;
    wire logic pin_next = pin_quiet ? 1'b0 : pin_raw ^ inv;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cmp_lvl_reg <= 1'b0;
            pulse_lvl_reg <= 1'b0;
            timer_output_pin <= 1'b0;
        end else begin
            cmp_lvl_reg <= cmp_lvl_next;
            pulse_lvl_reg <= pulse_lvl_next;
            timer_output_pin <= pin_next;
        end
    end

    // Compare A register takes the captured count two cycles after the edge
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cap_pend_reg <= 1'b0;
        end else begin
            cap_pend_reg <= do_cap;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_on_rise_clears;
        @(posedge sys_clk) disable iff (!rst_b)
        on_rise |=> cnt_reg == '0;
    endproperty
    a_on_rise_clears: assert property (p_on_rise_clears)
        else $error("counter not cleared by counter_on rise");

    property p_off_holds;
        @(posedge sys_clk) disable iff (!rst_b)
        !on_bit && !on_d_reg |=> $stable(cnt_reg);
    endproperty
    a_off_holds: assert property (p_off_holds)
        else $error("counter moved while off");

    property p_clr_a;
        @(posedge sys_clk) disable iff (!rst_b)
        mode == PTM_MODE_CMP && clr_src && a_match && !on_rise
        |=> cnt_reg == '0;
    endproperty
    a_clr_a: assert property (p_clr_a)
        else $error("A match did not clear counter");

    property p_clr_p;
        @(posedge sys_clk) disable iff (!rst_b)
        mode == PTM_MODE_CMP && !clr_src && per_reg != '0 && p_match
        && !on_rise |=> cnt_reg == '0;
    endproperty
    a_clr_p: assert property (p_clr_p)
        else $error("P match did not clear counter");

    property p_toggle;
        @(posedge sys_clk) disable iff (!rst_b)
        mode == PTM_MODE_CMP && pin_sel == 2'h3 && a_match && !on_rise
        |=> timer_output_pin != $past(timer_output_pin);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pin did not toggle on A match");

    property p_init_lvl;
        @(posedge sys_clk) disable iff (!rst_b)
        mode == PTM_MODE_CMP && on_rise |=> timer_output_pin == (lvl ^ inv);
    endproperty
    a_init_lvl: assert property (p_init_lvl)
        else $error("pin not at initial level after on rise");

    property p_force_active;
        @(posedge sys_clk) disable iff (!rst_b)
        mode == PTM_MODE_PWM && pin_sel == 2'h1 ##1 $stable(mode_reg)
        |-> timer_output_pin == (lvl ^ inv);
    endproperty
    a_force_active: assert property (p_force_active)
        else $error("forced active level wrong");

    property p_cap_source;
        @(posedge sys_clk) disable iff (!rst_b)
        mode == PTM_MODE_CAP && on_bit && pin_sel == 2'h0 && !cap_src
        && $stable(mode_reg) && $rose(capture_input_pin) |=> cap_pend_reg;
    endproperty
    a_cap_source: assert property (p_cap_source)
        else $error("capture pin edge not taken");

    property p_pulse_start;
        @(posedge sys_clk) disable iff (!rst_b)
        pulse_mode && on_rise |=> timer_output_pin == (lvl ^ inv);
    endproperty
    a_pulse_start: assert property (p_pulse_start)
        else $error("single pulse did not start at level bit");

endmodule : ptm_timer

//--- sim/ptm_pin_model.sv
// Pin-side partner: drives the capture and external clock pins and
// watches the timer output pin. Assumes the bench owns the clock.
`timescale 1ns/10ps

module ptm_pin_model (
    input wire logic sys_clk,
    input wire logic timer_output_pin,
    output logic capture_input_pin,
    output logic external_clock_pin
);
    initial begin
        capture_input_pin = 1'b0;
        external_clock_pin = 1'b0;
    end

    // --------------------------------------------------------------
    // Edge traffic on both trigger sources, at different rates
    // --------------------------------------------------------------
    task automatic toggle(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge sys_clk);
            capture_input_pin <= ~capture_input_pin;
            if (k[0])
                external_clock_pin <= ~external_clock_pin;
        end
    endtask : toggle

    // Sampled mid-cycle so the registered pin has settled
    task automatic count_lvl(input logic lvl, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge sys_clk);
            if (timer_output_pin === lvl)
                c++;
        end
    endtask : count_lvl
endmodule : ptm_pin_model

//--- sim/periodic_timer_mode_config_tb.sv
// Self-checking bench for the periodic timer over AHB-Lite.
// Assumes zero-wait slave and counting on every clock while enabled.
`timescale 1ns/10ps
`include "ptm_params.svh"

module periodic_timer_mode_config_tb;
    import ptm_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, cap_pin, ext_pin, out_pin;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] q;
    int c;
    logic [7:0] on_b = 8'h01 << `PTM_CTRL0_ON_BIT;

    always #2 sys_clk = ~sys_clk;

    ptm_timer dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .capture_input_pin(cap_pin), .external_clock_pin(ext_pin),
        .timer_output_pin(out_pin));

    ptm_pin_model pins (.sys_clk(sys_clk), .timer_output_pin(out_pin),
        .capture_input_pin(cap_pin), .external_clock_pin(ext_pin));

    // --------------------------------------------------------------
    // Checking and bus tasks
    // --------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Bounded wait so a stuck ready cannot hang the run
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                err_total++;
                test_done;
            end
            @(posedge sys_clk);
        end
    endtask : wait_rdy

    // Entered just after a rising edge; leaves just after one
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        wait_rdy;
        v = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] v;
        xfer(a, 1'b1, d, v);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        xfer(a, 1'b0, 8'h00, v);
    endtask : rd

    task automatic smp(input int n, output logic [31:0] v);
        repeat (n) @(negedge sys_clk);
        v = {31'h0, out_pin};
        @(posedge sys_clk);
    endtask : smp

    function automatic logic [7:0] mb(input logic [1:0] m,
        input logic [1:0] p, input logic l, input logic i,
        input logic s, input logic k);
        return {m, p, l, i, s, k};
    endfunction : mb

    // Stop points over eight phases cover every count of a short period
    task automatic sweep(input logic [7:0] mode, output logic [31:0] m);
        logic [31:0] v;
        m = 32'h0;
        wr(`PTM_OFS_MODE, mode);
        for (int d = 0; d < 8; d++) begin
            wr(`PTM_OFS_CTRL0, on_b);
            repeat (20 + d) @(posedge sys_clk);
            wr(`PTM_OFS_CTRL0, 8'h00);
            rd(`PTM_OFS_CNT_LO, v);
            if (v > m)
                m = v;
        end
    endtask : sweep

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 9; a++) begin
            rd(8'(a * 4), q);
            chk(q, 32'h0);
        end
        $display("test reset values done");

        wr(`PTM_OFS_CMPA_LO, 8'ha5);
        wr(`PTM_OFS_CMPA_HI, 8'hff);
        wr(`PTM_OFS_PER_LO, 8'h5a);
        wr(`PTM_OFS_PER_HI, 8'hfe);
        wr(`PTM_OFS_CNT_LO, 8'h77);
        wr(`PTM_OFS_CNT_HI, 8'h03);
        wr(`PTM_OFS_MODE, 8'hff);
        wr(8'h20, 8'hff);
        rd(`PTM_OFS_CMPA_LO, q); chk(q, 32'ha5);
        rd(`PTM_OFS_CMPA_HI, q); chk(q, 32'h03);
        rd(`PTM_OFS_PER_LO, q); chk(q, 32'h5a);
        rd(`PTM_OFS_PER_HI, q); chk(q, 32'h02);
        rd(`PTM_OFS_CNT_LO, q); chk(q, 32'h0);
        rd(`PTM_OFS_CNT_HI, q); chk(q, 32'h0);
        rd(`PTM_OFS_MODE, q); chk(q, 32'hff);
        rd(8'h20, q); chk(q, 32'h0);
        wr(`PTM_OFS_MODE, 8'h00);
        $display("test register access done");

        wr(`PTM_OFS_CMPA_LO, 8'h03);
        wr(`PTM_OFS_CMPA_HI, 8'h00);
        wr(`PTM_OFS_PER_LO, 8'h06);
        wr(`PTM_OFS_PER_HI, 8'h00);
        sweep(mb(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), q);
        chk(q, 32'h6);
        sweep(mb(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1), q);
        chk(q, 32'h3);
        sweep(mb(2'h1, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1), q);
        chk(q, 32'h6);
        wr(`PTM_OFS_CTRL0, on_b);
        repeat (5) @(posedge sys_clk);
        wr(`PTM_OFS_CTRL0, 8'h00);
        rd(`PTM_OFS_CNT_LO, q);
        chk(q, 32'h6);
        repeat (10) @(posedge sys_clk);
        rd(`PTM_OFS_CNT_LO, q);
        chk(q, 32'h6);
        $display("test counter clearing done");

        wr(`PTM_OFS_CMPA_LO, 8'd20);
        wr(`PTM_OFS_PER_LO, 8'h00);
        for (int l = 0; l < 2; l++)
            for (int i = 0; i < 2; i++)
                for (int p = 0; p < 4; p++) begin
                    logic e;
                    e = (p == 0) ? l[0] : (p == 1) ? 1'b0 :
                        (p == 2) ? 1'b1 : ~l[0];
                    wr(`PTM_OFS_MODE, mb(2'h0, p[1:0], l[0], i[0],
                        1'b0, 1'b0));
                    wr(`PTM_OFS_CTRL0, on_b);
                    smp(3, q); chk(q, {31'h0, l[0] ^ i[0]});
                    smp(40, q); chk(q, {31'h0, e ^ i[0]});
                    wr(`PTM_OFS_CTRL0, 8'h00);
                end
        $display("test compare output done");

        wr(`PTM_OFS_PER_LO, 8'd10);
        for (int l = 0; l < 2; l++)
            for (int i = 0; i < 2; i++) begin
                for (int p = 0; p < 2; p++) begin
                    wr(`PTM_OFS_MODE, mb(2'h2, p[1:0], l[0], i[0],
                        1'b0, 1'b0));
                    wr(`PTM_OFS_CTRL0, on_b);
                    smp(4, q);
                    chk(q, {31'h0, (p == 1 ? l[0] : ~l[0]) ^ i[0]});
                    wr(`PTM_OFS_CTRL0, 8'h00);
                end
                for (int a = 5; a < 13; a += 7) begin
                    wr(`PTM_OFS_CMPA_LO, 8'(a));
                    wr(`PTM_OFS_MODE, mb(2'h2, 2'h2, l[0], i[0],
                        1'b0, 1'b0));
                    wr(`PTM_OFS_CTRL0, on_b);
                    repeat (4) @(posedge sys_clk);
                    // Count runs 0 to P: 22 samples are two whole periods
                    pins.count_lvl(l[0] ^ i[0], 22, c);
                    @(posedge sys_clk);
                    chk(32'(c), a == 5 ? 32'd10 : 32'd22);
                    wr(`PTM_OFS_CTRL0, 8'h00);
                end
                wr(`PTM_OFS_CMPA_LO, 8'd8);
                wr(`PTM_OFS_MODE, mb(2'h2, 2'h3, l[0], i[0], 1'b0, 1'b0));
                wr(`PTM_OFS_CTRL0, on_b);
                smp(2, q); chk(q, {31'h0, l[0] ^ i[0]});
                smp(30, q); chk(q, {31'h0, ~l[0] ^ i[0]});
                rd(`PTM_OFS_CTRL0, q); chk(q, 32'h0);
            end
        $display("test pwm and single pulse done");

        for (int m = 1; m < 4; m += 2)
            for (int p = 0; p < 4; p++) begin
                wr(`PTM_OFS_CMPA_LO, 8'h55);
                wr(`PTM_OFS_MODE, mb(m[1:0], p[1:0], 1'b1, 1'b1,
                    p[0], 1'b0));
                wr(`PTM_OFS_CTRL0, on_b);
                pins.toggle(12);
                smp(2, q);
                chk(q, 32'h0);
                wr(`PTM_OFS_CTRL0, 8'h00);
                // Last active edge: a rise sees count 10, a fall sees 0
                rd(`PTM_OFS_CMPA_LO, q);
                chk(q, (m == 3 || p == 3) ? 32'h55 :
                    (p == 0 ? 32'd10 : 32'h0));
            end
        $display("test capture and timer modes done");
        test_done;
    end

    initial begin
        #200000;
        err_total++;
        test_done;
    end
endmodule : periodic_timer_mode_config_tb
